//--- core/nsl1_fsm.sv
// Purpose: Network-side layer 1 maintenance state machine.
// Assumes: Event inputs are single-cycle pulses from logic on ref_clk.
// Notes:   Disappearing-fault transitions are not handled here.
`default_nettype none
module nsl1_fsm
	import nsl1_pkg::*;
(
	input  wire logic    ref_clk,
	input  wire logic    rst,
	input  wire logic    power_loss,
	input  wire logic    power_return,
	input  wire logic    normal_cells,
	input  wire logic    internal_failure_a,
	input  wire logic    remote_defect_received,
	input  wire logic    internal_failure_b,
	input  wire logic    line_or_delineation_loss,
	output nsl1_state_t  state,
	output nsl1_tx_t     tx_signal,
	output logic         ph_activate,
	output logic         ph_deactivate,
	output logic         mph_activate,
	output logic         mph_err_power,
	output logic         mph_err_a,
	output logic         mph_err_remote,
	output logic         mph_err_b,
	output logic         mph_err_line,
	output logic         mph_clr_power
);
	// ------------------------------------------------------------
	// State, line signal and indication registers
	// ------------------------------------------------------------
	nsl1_state_t state_ff;
	nsl1_state_t nxt_state;
	nsl1_tx_t    tx_ff;
	nsl1_tx_t    nxt_tx;
	logic        ph_activate_ff;
	logic        nxt_ph_activate;
	logic        ph_deactivate_ff;
	logic        nxt_ph_deactivate;
	logic        mph_activate_ff;
	logic        nxt_mph_activate;
	logic        err_power_ff;
	logic        nxt_err_power;
	logic        err_a_ff;
	logic        nxt_err_a;
	logic        err_remote_ff;
	logic        nxt_err_remote;
	logic        err_b_ff;
	logic        nxt_err_b;
	logic        err_line_ff;
	logic        nxt_err_line;
	logic        clr_power_ff;
	logic        nxt_clr_power;
	logic        from_op;

	// ------------------------------------------------------------
	// Next state; events checked in priority order, one per cycle
	// ------------------------------------------------------------
	// Power events win over cell and failure events, so a supply
	// drop in the same cycle as a fault still parks the machine in
	// power off. Lower-priority events of that cycle are dropped and
	// give no pulse; the event source must raise them again.
	always_comb begin
		nxt_state         = state_ff;
		nxt_ph_activate   = 1'b0;
		nxt_ph_deactivate = 1'b0;
		nxt_mph_activate  = 1'b0;
		nxt_err_power     = 1'b0;
		nxt_err_a         = 1'b0;
		nxt_err_remote    = 1'b0;
		nxt_err_b         = 1'b0;
		nxt_err_line      = 1'b0;
		nxt_clr_power     = 1'b0;
		from_op           = (state_ff == operational_state);
		if (power_loss) begin
			if (state_ff != power_off_state) begin
				nxt_state         = power_off_state;
				nxt_err_power     = 1'b1;
				nxt_ph_deactivate = from_op;
			end
		end else if (power_return) begin
			if (state_ff == power_off_state) begin
				nxt_state     = power_on_wait_state;
				nxt_clr_power = 1'b1;
			end
		end else if (normal_cells) begin
			if (state_ff != power_off_state && !from_op) begin
				nxt_state        = operational_state;
				nxt_ph_activate  = 1'b1;
				nxt_mph_activate = 1'b1;
			end
		end else if (internal_failure_a) begin
			case (state_ff)
				operational_state,
				power_on_wait_state: nxt_state = st_fail_a;
				st_remote:           nxt_state = st_a_remote;
				st_line:             nxt_state = st_a_rem_line;
				st_fail_b:           nxt_state = st_a_b;
				st_rem_b:            nxt_state = st_a_rem_b;
				st_b_line:           nxt_state = st_b_line_all;
				default:             nxt_state = state_ff;
			endcase
			nxt_err_a         = (nxt_state != state_ff);
			nxt_ph_deactivate = from_op;
		end else if (remote_defect_received) begin
			case (state_ff)
				operational_state,
				power_on_wait_state: nxt_state = st_remote;
				st_fail_a:           nxt_state = st_a_remote;
				st_fail_b:           nxt_state = st_rem_b;
				st_a_b:              nxt_state = st_a_rem_b;
				default:             nxt_state = state_ff;
			endcase
			nxt_err_remote    = (nxt_state != state_ff);
			nxt_ph_deactivate = from_op;
		end else if (internal_failure_b) begin
			case (state_ff)
				operational_state,
				power_on_wait_state: nxt_state = st_fail_b;
				st_fail_a:           nxt_state = st_a_b;
				st_remote:           nxt_state = st_rem_b;
				st_line:             nxt_state = st_b_line;
				st_a_remote:         nxt_state = st_a_rem_b;
				st_a_rem_line:       nxt_state = st_b_line_all;
				default:             nxt_state = state_ff;
			endcase
			nxt_err_b         = (nxt_state != state_ff);
			nxt_ph_deactivate = from_op;
		end else if (line_or_delineation_loss) begin
			case (state_ff)
				operational_state,
				st_remote:           nxt_state = st_line;
				st_fail_a,
				st_a_remote:         nxt_state = st_a_rem_line;
				st_fail_b,
				st_rem_b:            nxt_state = st_b_line;
				st_a_b,
				st_a_rem_b:          nxt_state = st_b_line_all;
				default:             nxt_state = state_ff;
			endcase
			nxt_err_line      = (nxt_state != state_ff);
			nxt_ph_deactivate = from_op;
		end
		// Ignored or impossible events leave everything untouched; this also
		// drops a deactivation raised by a no-change event in operational
		if (nxt_state == state_ff) begin
			nxt_ph_activate   = 1'b0;
			nxt_ph_deactivate = 1'b0;
			nxt_mph_activate  = 1'b0;
			nxt_err_power     = 1'b0;
			nxt_err_a         = 1'b0;
			nxt_err_remote    = 1'b0;
			nxt_err_b         = 1'b0;
			nxt_err_line      = 1'b0;
			nxt_clr_power     = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Transmitted signal follows the next state
	// ------------------------------------------------------------
	always_comb begin
		case (nxt_state)
			power_off_state,
			power_on_wait_state: nxt_tx = tx_none;
			st_fail_a:           nxt_tx = tx_path_rdi;
			st_a_rem_line:       nxt_tx = tx_sec_path_rdi;
			st_b_line,
			st_b_line_all:       nxt_tx = tx_ais_sec_rdi;
			st_fail_b,
			st_a_b,
			st_rem_b,
			st_a_rem_b:          nxt_tx = tx_path_ais;
			default:             nxt_tx = tx_normal;
		endcase
	end

	// ------------------------------------------------------------
	// State and line signal registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= power_off_state;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Taken from the next state so content and state switch on one edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_ff <= tx_none;
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	// ------------------------------------------------------------
	// Indication pulses, registered together with the state change
	// ------------------------------------------------------------
	// One flop per primitive keeps each indication its own concern
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ph_activate_ff <= 1'b0;
		end else begin
			ph_activate_ff <= nxt_ph_activate;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ph_deactivate_ff <= 1'b0;
		end else begin
			ph_deactivate_ff <= nxt_ph_deactivate;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mph_activate_ff <= 1'b0;
		end else begin
			mph_activate_ff <= nxt_mph_activate;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_power_ff <= 1'b0;
		end else begin
			err_power_ff <= nxt_err_power;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_a_ff <= 1'b0;
		end else begin
			err_a_ff <= nxt_err_a;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_remote_ff <= 1'b0;
		end else begin
			err_remote_ff <= nxt_err_remote;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_b_ff <= 1'b0;
		end else begin
			err_b_ff <= nxt_err_b;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_line_ff <= 1'b0;
		end else begin
			err_line_ff <= nxt_err_line;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clr_power_ff <= 1'b0;
		end else begin
			clr_power_ff <= nxt_clr_power;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign state          = state_ff;
	assign tx_signal      = tx_ff;
	assign ph_activate    = ph_activate_ff;
	assign ph_deactivate  = ph_deactivate_ff;
	assign mph_activate   = mph_activate_ff;
	assign mph_err_power  = err_power_ff;
	assign mph_err_a      = err_a_ff;
	assign mph_err_remote = err_remote_ff;
	assign mph_err_b      = err_b_ff;
	assign mph_err_line   = err_line_ff;
	assign mph_clr_power  = clr_power_ff;
endmodule
`default_nettype wire

//--- core/nsl1_pkg.sv
// Purpose: Shared types and constants for the network-side layer 1 state machine.
// Assumes: One clock domain, synchronous reset.
// Notes:   Transmit signal codes select the maintenance content sent to the line.
`default_nettype none
package nsl1_pkg;
	// ------------------------------------------------------------
	// State encoding (Gray along power off -> wait -> operational)
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		power_off_state     = 4'h0,
		power_on_wait_state = 4'h1,
		operational_state   = 4'h3,
		st_fail_a           = 4'h2,
		st_remote           = 4'h6,
		st_fail_b           = 4'h7,
		st_line             = 4'h5,
		st_a_remote         = 4'h4,
		st_a_b              = 4'hc,
		st_a_rem_line       = 4'hd,
		st_rem_b            = 4'hf,
		st_b_line           = 4'he,
		st_a_rem_b          = 4'ha,
		st_b_line_all       = 4'hb
	} nsl1_state_t;

	// ------------------------------------------------------------
	// Transmitted signal selection
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		tx_none       = 3'h0,
		tx_normal     = 3'h1,
		tx_path_rdi   = 3'h2,
		tx_path_ais   = 3'h3,
		tx_sec_path_rdi = 3'h4,
		tx_ais_sec_rdi  = 3'h5
	} nsl1_tx_t;
endpackage
`default_nettype wire

//--- tb/nsl1_fsm_bench.sv
// Purpose: Random event run. Assumes: One event a cycle. Notes: Nibble tables give next state.
`default_nettype none
module nsl1_fsm_bench import nsl1_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, cells, rdi;
	logic [6:0] ev = '0;
	logic [8:0] pul;
	nsl1_state_t state;
	nsl1_tx_t tx_signal;
	int n_fail = 0, n_tests = 0, cyc = 0;
	logic [55:0] tbl [4] = '{56'h2f_fcbf_ff87_6f2f, 56'h3f_ffff_bff9_f63f,
		56'h4f_fffc_fbaf_974f, 56'hff_cfaf_c8fa_585f};
	nsl1_state_t g2s [14] = '{power_off_state, operational_state, st_fail_a, st_remote,
		st_fail_b, st_line, st_a_remote, st_a_b, st_a_rem_line, st_rem_b, st_b_line,
		st_a_rem_b, st_b_line_all, power_on_wait_state};
	// 7 marks a state whose line content is left open
	logic [2:0] txe [14] = '{tx_none, tx_normal, tx_path_rdi, tx_normal, tx_path_ais, 3'h7,
		3'h7, tx_path_ais, tx_sec_path_rdi, tx_path_ais, tx_ais_sec_rdi, tx_path_ais,
		tx_ais_sec_rdi, tx_none};
	initial forever #2.5 ref_clk = ~ref_clk;
	nsl1_user u_user (.send_cells(ev[2]), .send_rdi(ev[4]), .normal_cells(cells),
		.remote_defect_received(rdi));
	nsl1_fsm u_dut (.ref_clk, .rst, .power_loss(ev[0]), .power_return(ev[1]),
		.normal_cells(cells), .internal_failure_a(ev[3]), .remote_defect_received(rdi),
		.internal_failure_b(ev[5]), .line_or_delineation_loss(ev[6]), .state, .tx_signal,
		.ph_activate(pul[8]), .ph_deactivate(pul[7]), .mph_activate(pul[6]),
		.mph_err_power(pul[5]), .mph_err_a(pul[4]), .mph_err_remote(pul[3]),
		.mph_err_b(pul[2]), .mph_err_line(pul[1]), .mph_clr_power(pul[0]));
	function automatic void step(input int e, inout int g, output logic [8:0] p);
		int t;
		p = '0;
		t = 15;
		case (e)
			0: if (g != 0) begin
				t = 0;
				p = {1'b0, g == 1, 7'h20};
			end
			1: if (g == 0) begin
				t = 13;
				p = 9'h001;
			end
			2: if (g > 1) begin
				t = 1;
				p = 9'h140;
			end
			3, 4, 5, 6: begin
				t = tbl[e - 3][g * 4 +: 4];
				if (t != 15) p = {1'b0, g == 1, 7'h01 << (7 - e)};
			end
			default: t = 15;
		endcase
		if (t != 15) g = t;
	endfunction
	task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task finish_test();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		int g, e;
		logic [8:0] p;
		int seq [9] = '{0, 1, 6, 2, 6, 4, 5, 3, 0};
		void'($urandom(32'hd93d_3d41));
		g = 0;
		p = '0;
		repeat (10) @(posedge ref_clk);
		rst <= 0;
		for (int i = 0; i < 2009; i++) begin
			@(posedge ref_clk);
			e = (i < 9) ? seq[i] : $urandom_range(7);
			ev <= (e < 7) ? 7'h01 << e : 7'h00;
			@(negedge ref_clk);
			chk("pulses", p, pul);
			chk("state", 9'(g2s[g]), 9'(state));
			if (txe[g] != 3'h7) chk("tx", 9'(txe[g]), 9'(tx_signal));
			step(e, g, p);
		end
		finish_test();
	end
endmodule
`default_nettype wire

//--- tb/nsl1_props.sv
// Purpose: Port checks. Assumes: One clock. Notes: Bound after the module.
`default_nettype none
module nsl1_props import nsl1_pkg::*; (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        power_loss,
	input wire logic        power_return,
	input wire logic        normal_cells,
	input wire logic        ph_activate,
	input wire logic        ph_deactivate,
	input wire logic        mph_activate,
	input wire logic        mph_err_power,
	input wire logic        mph_clr_power,
	input wire nsl1_state_t state,
	input wire nsl1_tx_t    tx_signal
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_off;
		state == power_off_state && mph_err_power;
	endsequence
	a_idle_quiet: assert property (state inside {power_off_state, power_on_wait_state}
		|-> tx_signal == tx_none) else $error("tx not idle");
	a_fail_rdi: assert property (state == st_fail_a |-> tx_signal == tx_path_rdi)
		else $error("tx not rdi");
	a_comb_rdi: assert property (state == st_a_rem_line |-> tx_signal == tx_sec_path_rdi)
		else $error("tx not both rdi");
	a_line_ais: assert property (state inside {st_b_line, st_b_line_all}
		|-> tx_signal == tx_ais_sec_rdi) else $error("tx not ais rdi");
	a_b_ais: assert property (state inside {st_fail_b, st_a_b, st_rem_b, st_a_rem_b}
		|-> tx_signal == tx_path_ais) else $error("tx not ais");
	a_loss_off: assert property (power_loss && state != power_off_state |=> s_off)
		else $error("no power off");
	a_return_wait: assert property (!power_loss && power_return && state == power_off_state
		|=> state == power_on_wait_state && mph_clr_power) else $error("no wait");
	a_cells_act: assert property (normal_cells && !power_loss && !power_return
		&& !(state inside {power_off_state, operational_state})
		|=> state == operational_state && ph_activate && mph_activate) else $error("no activate");
	a_deact_src: assert property (ph_deactivate |-> $past(state) == operational_state)
		else $error("stray deactivate");
endmodule
bind nsl1_fsm nsl1_props u_props (.*);
`default_nettype wire

//--- tb/nsl1_user.sv
// Purpose: User side stand-in. Assumes: One clock. Notes: Sends only on request.
`default_nettype none
module nsl1_user (
	input wire logic send_cells,
	input wire logic send_rdi,
	output logic     normal_cells,
	output logic     remote_defect_received
);
	assign normal_cells = send_cells;
	assign remote_defect_received = send_rdi;
endmodule
`default_nettype wire
